/* src/gain_chan_pkg.sv */
// constants shared by the gain and channel select control
package gain_chan_pkg;

   // -------------------------------------------------------------
   // transfer instruction decode
   // -------------------------------------------------------------
   localparam logic [2:0] IOT_OPCODE       = 3'h6;
   localparam logic [5:0] DEV_LINE_CLOCK   = 6'h0C;
   localparam logic [5:0] DEV_GAIN         = 6'h0D;
   localparam logic [5:0] DEV_CONSOLE_OUT  = 6'h0E;
   localparam logic [5:0] DEV_CONSOLE_IN   = 6'h0F;
   localparam int         PULSES           = 3;

   // -------------------------------------------------------------
   // amplifier gain register
   // -------------------------------------------------------------
   localparam int         GAIN_MODE_BIT    = 5;
   localparam int         GAIN_SEL_FIRST   = 6;
   localparam int         GAIN_SEL_LAST    = 11;
   localparam int         GAIN_WIDTH       = 7;
   localparam int         GAIN_SELECTS     = 6;
   localparam logic [6:0] GAIN_RESET       = 7'h00;
   localparam logic [3:0] HIGH_FB_OFFSET   = 4'h3;
   localparam logic [3:0] GAIN_EXP_MAX     = 4'h8;

   // -------------------------------------------------------------
   // channel matrix and console
   // -------------------------------------------------------------
   localparam int         MATRIX_SIZE      = 8;
   localparam int         CONSOLE_GROUPS   = 8;
   localparam int         CHANNELS         = CONSOLE_GROUPS * MATRIX_SIZE;
   localparam int         CONSOLE_FIRST    = 6;
   localparam int         CONSOLE_WIDTH    = 6;
   localparam logic [5:0] CONSOLE_RESET    = 6'h00;
   localparam int         BUTTONS          = 3;
   localparam int         BTN_CLEAR        = 0;
   localparam int         BTN_START        = 1;
   localparam int         BTN_STOP         = 2;
   localparam int         MIX_CLEAR_BIT    = 6;
   localparam int         MIX_START_BIT    = 7;
   localparam int         MIX_STOP_BIT     = 8;
   localparam int         MIX_SPARE_A_BIT  = 9;
   localparam int         MIX_SPARE_B_BIT  = 10;
   localparam int         MIX_PRESENT_BIT  = 11;

endpackage

/* src/device_select_if.sv */
// decoded command levels from one device selector
`timescale 1ns/10ps
`default_nettype none
interface device_select_if;
   logic [2:0] cmd;
   modport sel  (output cmd);
   modport user (input  cmd);
endinterface
`default_nettype wire

/* src/io_device_select.sv */
// device selector: instruction word and pulse strobes to command levels
`timescale 1ns/10ps
`default_nettype none
module io_device_select #(
   parameter logic [5:0] DEVICE_CODE = 6'h00
) (
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   input  wire logic [0:11] mbWord,
   input  wire logic [2:0]  ioPulse,
   device_select_if.sel     cmdPort
);

   typedef struct packed {
      logic [2:0] cmd;
   } sel_state_s;

   sel_state_s stateQ;
   sel_state_s stateD;
   logic       codeHit;

   assign codeHit = (mbWord[0:2] == gain_chan_pkg::IOT_OPCODE)
                    && (mbWord[3:8] == DEVICE_CODE);

   always_comb
   begin
      stateD = stateQ;
      // command only with matching code and pulse
      for (int p = 0; p < gain_chan_pkg::PULSES; p++)
      begin
         stateD.cmd[p] = codeHit && mbWord[11 - p] && ioPulse[p];
      end
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         stateQ <= '0;
      else
         stateQ <= stateD;
   end

   assign cmdPort.cmd = stateQ.cmd;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   a_cmd_needs_code: assert property (cmdPort.cmd[0] |-> $past(codeHit && mbWord[11] && ioPulse[0]))
      else $error("command without matching code and pulse");
   a_cmd_follows_pulse: assert property ((codeHit && mbWord[10] && ioPulse[1]) |=> cmdPort.cmd[1])
      else $error("decoded pulse two not seen");

endmodule // io_device_select
`default_nettype wire

/* src/line_clock_flag.sv */
// line-synchronous clock flag, skip and interrupt
`timescale 1ns/10ps
`default_nettype none
module line_clock_flag (
   input  wire logic    core_clk,
   input  wire logic    arst_n,
   input  wire logic    lineTickPin,
   device_select_if.user cmdPort,
   output logic         clockSkip,
   output logic         clockIrq
);

   typedef struct packed {
      logic tickS1;
      logic tickS2;
      logic tickPrev;
      logic enable;
      logic flag;
      logic skip;
      logic irq;
   } clk_state_s;

   clk_state_s stateQ;
   clk_state_s stateD;
   logic       tickEdge;

   assign tickEdge = stateQ.tickS2 && !stateQ.tickPrev;

   always_comb
   begin
      stateD          = stateQ;
      stateD.tickS1   = lineTickPin;
      stateD.tickS2   = stateQ.tickS1;
      stateD.tickPrev = stateQ.tickS2;
      if (cmdPort.cmd[2])
         stateD.enable = 1'b1;
      // flag from line tick, set beats clear
      if (tickEdge && stateQ.enable)
         stateD.flag = 1'b1;
      else if (cmdPort.cmd[1])
         stateD.flag = 1'b0;
      stateD.skip = cmdPort.cmd[0] && stateQ.flag;
      stateD.irq  = stateD.flag && stateD.enable;
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         stateQ <= '0;
      else
         stateQ <= stateD;
   end

   assign clockSkip = stateQ.skip;
   assign clockIrq  = stateQ.irq;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   a_flag_set_wins: assert property ((tickEdge && stateQ.enable) |=> (stateQ.flag && clockIrq))
      else $error("line tick lost or interrupt missing");
   a_skip_on_flag: assert property (clockSkip |-> $past(cmdPort.cmd[0] && stateQ.flag))
      else $error("skip without flag");

endmodule // line_clock_flag
`default_nettype wire

/* src/gain_channel_ctrl.sv */
// gain register, channel matrix and console control behind the I/O bus
`timescale 1ns/10ps
`default_nettype none

// Contract
// - gain-clear instruction zeroes all gain bits, giving low feedback mode.
// - gain-load sets each gain bit whose accumulator bit is one.
// - gain register loads from buffered accumulator bits 5 to 11.
// - accumulator bit 5 during gain-load selects high feedback mode.
// - relay drives follow feedback mode and the set gain-select bit.
// - gain steps in powers of two, unity up to 256.
// - eight by eight matrix decodes sixty-four channel select lines.
// - incoming row and column lines are buffered and inverted.
// - a channel selects, active low, when its row and column are high.
// - device select combines instruction word with pulse strobes.
// - line clock gives one interrupt and a skip to the processor.
// - selected channel pushbuttons reach the input mixer bus.
// - console lamps and relays change only on the selected channel.
// - console logic comes in groups of eight, up to 64.
// - output-clear zeroes, output-load sets selected console register bits.
// - input-read puts console inputs on mixer bits 6 to 11.
module gain_channel_ctrl (
   input  wire logic          core_clk,
   input  wire logic          arst_n,
   input  wire logic [0:11]   memoryBufferWord,
   input  wire logic [2:0]    ioPulseStrobe,
   input  wire logic [0:11]   bufferedAccumulatorBits,
   input  wire logic [7:0]    columnLine_n,
   input  wire logic [7:0]    rowLine_n,
   input  wire logic [191:0]  consoleButtons,
   input  wire logic          lineTickPin,
   output logic [0:11]        inputMixerBus,
   output logic               ioSkip,
   output logic               programInterrupt,
   output logic               lowFeedbackRelay,
   output logic               highFeedbackRelay,
   output logic [5:0]         gainRelay,
   output logic [3:0]         gainExponent,
   output logic [63:0]        channelSelect_n,
   output logic [383:0]       consoleLampsRelays
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [0:11]  mbS1;
      logic [0:11]  mbS2;
      logic [2:0]   iopS1;
      logic [2:0]   iopS2;
      logic [0:11]  bacS1;
      logic [0:11]  bacS2;
      logic [7:0]   colS1;
      logic [7:0]   colS2;
      logic [7:0]   rowS1;
      logic [7:0]   rowS2;
      logic [191:0] btnS1;
      logic [191:0] btnS2;
      logic [0:6]   gain;
      logic         lowFb;
      logic         highFb;
      logic [5:0]   relay;
      logic [3:0]   gainExp;
      logic [63:0]  selN;
      logic [383:0] console;
      logic [0:11]  mixer;
   } top_state_s;

   top_state_s stateQ;
   top_state_s stateD;

   device_select_if gainCmd ();
   device_select_if outCmd ();
   device_select_if inCmd ();
   device_select_if clkCmd ();

   // ----------------------------------------------------------------
   // device selectors
   // ----------------------------------------------------------------
   io_device_select #(.DEVICE_CODE(gain_chan_pkg::DEV_GAIN)) gainSelect (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .mbWord   (stateQ.mbS2),
      .ioPulse  (stateQ.iopS2),
      .cmdPort  (gainCmd)
   );

   io_device_select #(.DEVICE_CODE(gain_chan_pkg::DEV_CONSOLE_OUT)) outSelect (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .mbWord   (stateQ.mbS2),
      .ioPulse  (stateQ.iopS2),
      .cmdPort  (outCmd)
   );

   io_device_select #(.DEVICE_CODE(gain_chan_pkg::DEV_CONSOLE_IN)) inSelect (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .mbWord   (stateQ.mbS2),
      .ioPulse  (stateQ.iopS2),
      .cmdPort  (inCmd)
   );

   io_device_select #(.DEVICE_CODE(gain_chan_pkg::DEV_LINE_CLOCK)) clkSelect (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .mbWord   (stateQ.mbS2),
      .ioPulse  (stateQ.iopS2),
      .cmdPort  (clkCmd)
   );

   line_clock_flag lineClock (
      .core_clk    (core_clk),
      .arst_n      (arst_n),
      .lineTickPin (lineTickPin),
      .cmdPort     (clkCmd),
      .clockSkip   (ioSkip),
      .clockIrq    (programInterrupt)
   );

   // ----------------------------------------------------------------
   // gain step: position of the select bit, shifted up in high mode
   // ----------------------------------------------------------------
   function automatic logic [3:0] gain_exponent(input logic [0:6] g);
      logic [3:0] e;
      e = 4'h0;
      for (int i = 1; i <= gain_chan_pkg::GAIN_SELECTS; i++)
      begin
         if (g[i])
            e = 4'(i - 1);
      end
      if (g[0])
         e = e + gain_chan_pkg::HIGH_FB_OFFSET;
      return e;
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      stateD = stateQ;

      // pins pass two flops before use
      stateD.mbS1  = memoryBufferWord;
      stateD.mbS2  = stateQ.mbS1;
      stateD.iopS1 = ioPulseStrobe;
      stateD.iopS2 = stateQ.iopS1;
      stateD.bacS1 = bufferedAccumulatorBits;
      stateD.bacS2 = stateQ.bacS1;
      stateD.colS1 = columnLine_n;
      stateD.colS2 = stateQ.colS1;
      stateD.rowS1 = rowLine_n;
      stateD.rowS2 = stateQ.rowS1;
      stateD.btnS1 = consoleButtons;
      stateD.btnS2 = stateQ.btnS1;

      if (gainCmd.cmd[0])
         stateD.gain = gain_chan_pkg::GAIN_RESET;
      // load from accumulator bits 5 to 11
      if (gainCmd.cmd[1])
         stateD.gain = stateD.gain
                       | stateQ.bacS2[gain_chan_pkg::GAIN_MODE_BIT:gain_chan_pkg::GAIN_SEL_LAST];

      // relay drives from mode and select bits
      // several set selects simply close several relays
      stateD.highFb = stateQ.gain[0];
      stateD.lowFb  = !stateQ.gain[0];
      for (int i = 0; i < gain_chan_pkg::GAIN_SELECTS; i++)
      begin
         stateD.relay[i] = stateQ.gain[1 + i];
      end
      stateD.gainExp = gain_exponent(stateQ.gain);

      // column five with row one is channel 15 octal
      for (int ch = 0; ch < gain_chan_pkg::CHANNELS; ch++)
      begin
         stateD.selN[ch] = !(!stateQ.colS2[ch % gain_chan_pkg::MATRIX_SIZE]
                             && !stateQ.rowS2[ch / gain_chan_pkg::MATRIX_SIZE]);
      end

      // channel count set by group count
      // clear then set from accumulator bits 6 to 11
      for (int ch = 0; ch < gain_chan_pkg::CHANNELS; ch++)
      begin
         if (!stateQ.selN[ch])
         begin
            if (outCmd.cmd[0])
               stateD.console[ch * gain_chan_pkg::CONSOLE_WIDTH +: gain_chan_pkg::CONSOLE_WIDTH]
                  = gain_chan_pkg::CONSOLE_RESET;
            if (outCmd.cmd[1])
            begin
               for (int j = 0; j < gain_chan_pkg::CONSOLE_WIDTH; j++)
               begin
                  stateD.console[ch * gain_chan_pkg::CONSOLE_WIDTH + j]
                     = stateD.console[ch * gain_chan_pkg::CONSOLE_WIDTH + j]
                       | stateQ.bacS2[gain_chan_pkg::CONSOLE_FIRST + j];
               end
            end
         end
      end

      // read into bits 6 to 11, spare and present bits high
      stateD.mixer = '0;
      if (inCmd.cmd[1])
      begin
         for (int ch = 0; ch < gain_chan_pkg::CHANNELS; ch++)
         begin
            if (!stateQ.selN[ch])
            begin
               stateD.mixer[gain_chan_pkg::MIX_CLEAR_BIT] = stateD.mixer[gain_chan_pkg::MIX_CLEAR_BIT]
                  | stateQ.btnS2[ch * gain_chan_pkg::BUTTONS + gain_chan_pkg::BTN_CLEAR];
               stateD.mixer[gain_chan_pkg::MIX_START_BIT] = stateD.mixer[gain_chan_pkg::MIX_START_BIT]
                  | stateQ.btnS2[ch * gain_chan_pkg::BUTTONS + gain_chan_pkg::BTN_START];
               stateD.mixer[gain_chan_pkg::MIX_STOP_BIT] = stateD.mixer[gain_chan_pkg::MIX_STOP_BIT]
                  | stateQ.btnS2[ch * gain_chan_pkg::BUTTONS + gain_chan_pkg::BTN_STOP];
               // lets software see the strobe without pressing a button
               stateD.mixer[gain_chan_pkg::MIX_SPARE_A_BIT] = 1'b1;
               stateD.mixer[gain_chan_pkg::MIX_SPARE_B_BIT] = 1'b1;
               stateD.mixer[gain_chan_pkg::MIX_PRESENT_BIT] = 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // registers; power clear puts lamps and gain relays off, low feedback relay on
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         stateQ        <= '0;
         stateQ.lowFb  <= 1'b1;
         stateQ.selN   <= '1;
         stateQ.colS1  <= '1;
         stateQ.colS2  <= '1;
         stateQ.rowS1  <= '1;
         stateQ.rowS2  <= '1;
      end
      else
         stateQ <= stateD;
   end

   assign inputMixerBus      = stateQ.mixer;
   assign lowFeedbackRelay   = stateQ.lowFb;
   assign highFeedbackRelay  = stateQ.highFb;
   assign gainRelay          = stateQ.relay;
   assign gainExponent       = stateQ.gainExp;
   assign channelSelect_n    = stateQ.selN;
   assign consoleLampsRelays = stateQ.console;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   a_gain_clear_zero: assert property ((gainCmd.cmd[0] && !gainCmd.cmd[1]) |=> (stateQ.gain == 7'h00))
      else $error("gain not cleared");
   a_gain_load_sets: assert property (gainCmd.cmd[1] |=> ((stateQ.gain & $past(stateQ.bacS2[5:11])) == $past(stateQ.bacS2[5:11])))
      else $error("gain load lost a one bit");
   a_gain_high_mode: assert property ((gainCmd.cmd[1] && stateQ.bacS2[5]) |=> ##1 (highFeedbackRelay && !lowFeedbackRelay))
      else $error("high feedback not selected");
   a_relay_follows_gain: assert property (##1 (gainRelay[0] == $past(stateQ.gain[1]) && gainRelay[5] == $past(stateQ.gain[6])))
      else $error("relay drive does not follow gain bits");
   // both ends of the span, so a wrong offset or a wrong index shows
   a_gain_span: assert property ((highFeedbackRelay && gainRelay == 6'h20)
      |-> (gainExponent == gain_chan_pkg::GAIN_EXP_MAX))
      else $error("top gain step is not 256");
   a_gain_unity: assert property ((lowFeedbackRelay && gainRelay == 6'h01)
      |-> (gainExponent == 4'h0))
      else $error("lowest gain step is not unity");
   a_matrix_example: assert property ((stateQ.colS2 == 8'hDF && stateQ.rowS2 == 8'hFD) |=> (!channelSelect_n[13] && channelSelect_n[12]))
      else $error("matrix decode wrong for channel 15 octal");
   a_matrix_one_hot: assert property (($onehot(~stateQ.colS2) && $onehot(~stateQ.rowS2))
      |=> $onehot(~channelSelect_n))
      else $error("matrix did not select exactly one channel");
   a_console_hold: assert property (stateQ.selN[0] |=> (consoleLampsRelays[5:0] == $past(consoleLampsRelays[5:0])))
      else $error("unselected console changed");
   a_console_clear: assert property ((outCmd.cmd[0] && !outCmd.cmd[1] && !stateQ.selN[0]) |=> (consoleLampsRelays[5:0] == 6'h00))
      else $error("console register not cleared");
   a_console_load: assert property ((outCmd.cmd[1] && !stateQ.selN[0] && stateQ.bacS2[6])
      |=> consoleLampsRelays[0])
      else $error("console load lost a one bit");
   a_mixer_read: assert property ((inCmd.cmd[1] && !stateQ.selN[0]) |=> (inputMixerBus[11] && inputMixerBus[7] == $past(stateQ.btnS2[1])))
      else $error("console read wrong");
   a_mixer_idle: assert property (!inCmd.cmd[1] |=> (inputMixerBus == 12'h000))
      else $error("mixer driven without read");

endmodule // gain_channel_ctrl
`default_nettype wire

/* verification/io_bus_model.sv */
// processor i/o bus model: transfer word, pulse strobes and accumulator
`timescale 1ns/10ps
`default_nettype none
module io_bus_model (
   input  wire logic   core_clk,
   output logic [0:11] memoryBufferWord,
   output logic [2:0]  ioPulseStrobe,
   output logic [0:11] bufferedAccumulatorBits,
   output logic        snoop
);
   initial
   begin
      memoryBufferWord = 12'h000;
      ioPulseStrobe = 3'h0;
      bufferedAccumulatorBits = 12'h000;
      snoop = 1'b0;
   end

   function automatic logic [0:11] gain_word(input int mode, input int sel, input logic [4:0] fill);
      logic [0:11] w;
      w = 12'h000;
      w[0:4] = fill;
      w[5] = mode[0];
      w[6 + sel] = 1'b1;
      return w;
   endfunction

   // ----------
   // one transfer: word and data stand across all three pulses
   // ----------
   task automatic io_transfer_instruction(input logic [0:11] word, input logic [0:11] ac, input int snoopPulse,
                      input int hold);
      @(negedge core_clk);
      memoryBufferWord = word;
      bufferedAccumulatorBits = ac;
      for (int p = 0; p < 3; p++)
      begin
         @(negedge core_clk);
         ioPulseStrobe = 3'(1 << p);
         repeat (hold) @(negedge core_clk);
         if (p == snoopPulse)
         begin
            snoop = 1'b1;
            @(posedge core_clk);
            snoop = 1'b0;
            @(negedge core_clk);
         end
         ioPulseStrobe = 3'h0;
         repeat (2) @(negedge core_clk);
      end
      // released lines show the inverse, never a stale copy
      memoryBufferWord = ~word;
      bufferedAccumulatorBits = ~ac;
   endtask
endmodule // io_bus_model
`default_nettype wire

/* verification/tb_gain_channel_ctrl.sv */
// self-checking bench for the gain and channel select control
`timescale 1ns/10ps
`default_nettype none
module tb_gain_channel_ctrl;
   typedef struct {int kind; int idx; logic [63:0] exp;} note_s;
   logic           core_clk;
   logic           arst_n;
   logic [0:11]    memoryBufferWord;
   logic [2:0]     ioPulseStrobe;
   logic [0:11]    bufferedAccumulatorBits;
   logic [7:0]     columnLine_n;
   logic [7:0]     rowLine_n;
   logic [191:0]   consoleButtons;
   logic           lineTickPin;
   logic [0:11]    inputMixerBus;
   logic           ioSkip;
   logic           programInterrupt;
   logic           lowFeedbackRelay;
   logic           highFeedbackRelay;
   logic [5:0]     gainRelay;
   logic [3:0]     gainExponent;
   logic [63:0]    channelSelect_n;
   logic [383:0]   consoleLampsRelays;
   logic           snoop;
   logic [0:11]    ac;
   logic [0:11]    mix;
   logic [5:0]     v;
   int             miscompares;
   int             n_compared;
   int             x;
   int             y;
   int             c;
   int             chList[8] = '{0, 9, 18, 27, 36, 45, 54, 62};
   note_s          notes[$];
   event           obsEv;

   gain_channel_ctrl u_gain_channel_ctrl (.core_clk(core_clk), .arst_n(arst_n),
      .memoryBufferWord(memoryBufferWord), .ioPulseStrobe(ioPulseStrobe),
      .bufferedAccumulatorBits(bufferedAccumulatorBits), .columnLine_n(columnLine_n),
      .rowLine_n(rowLine_n), .consoleButtons(consoleButtons), .lineTickPin(lineTickPin),
      .inputMixerBus(inputMixerBus), .ioSkip(ioSkip), .programInterrupt(programInterrupt),
      .lowFeedbackRelay(lowFeedbackRelay), .highFeedbackRelay(highFeedbackRelay),
      .gainRelay(gainRelay), .gainExponent(gainExponent), .channelSelect_n(channelSelect_n),
      .consoleLampsRelays(consoleLampsRelays));

   io_bus_model u_io_bus_model (.core_clk(core_clk), .memoryBufferWord(memoryBufferWord),
      .ioPulseStrobe(ioPulseStrobe), .bufferedAccumulatorBits(bufferedAccumulatorBits),
      .snoop(snoop));

   always #4 core_clk = ~core_clk;
   // mid-transfer sample point comes from the bus model
   always @(posedge snoop) -> obsEv;

   // ----------
   // checking
   // ----------
   task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
      n_compared++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic note(input int kind, input int idx, input logic [63:0] exp, input bit now);
      notes.push_back('{kind, idx, exp});
      if (now)
      begin
         -> obsEv;
         // a second trigger in the same time step would be lost
         wt(1);
      end
   endtask

   always @(obsEv)
   begin : watch
      note_s n;
      if (notes.size() == 0)
      begin
         miscompares++;
         $display("[FAIL] %0t sample without note", $time);
      end
      else
      begin
         n = notes.pop_front();
         case (n.kind)
            0: check({52'h0, highFeedbackRelay, lowFeedbackRelay, gainRelay, gainExponent}, n.exp, "gain");
            1: check(channelSelect_n, n.exp, "matrix");
            2: check({52'h0, inputMixerBus}, n.exp, "mixer");
            3: check({52'h0, consoleLampsRelays[n.idx*6 +: 12]}, n.exp, "lamps");
            default: check({62'h0, ioSkip, programInterrupt}, n.exp, "clock");
         endcase
      end
   end

   task automatic finish_test();
      if (notes.size() != 0)
      begin
         miscompares++;
         $display("[FAIL] %0t %0d notes never checked", $time, notes.size());
      end
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic wt(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   function automatic int hd();
      return 5 + int'($urandom % 4);
   endfunction

   task automatic tick();
      lineTickPin = 1'b1;
      wt(4);
      lineTickPin = 1'b0;
      wt(4);
   endtask

   initial
   begin
      #200us;
      miscompares++;
      $display("[FAIL] %0t watchdog expired", $time);
      finish_test();
   end

   // ----------
   // scenarios
   // ----------
   initial
   begin
      core_clk = 1'b0;
      arst_n = 1'b0;
      columnLine_n = 8'hFF;
      rowLine_n = 8'hFF;
      consoleButtons = '0;
      lineTickPin = 1'b0;
      void'($urandom(5685));
      wt(8);
      arst_n = 1'b1;
      wt(2);
      note(0, 0, 64'h400, 1);
      note(1, 0, 64'hFFFF_FFFF_FFFF_FFFF, 1);
      note(2, 0, 64'h0, 1);
      note(3, 0, 64'h0, 1);
      note(4, 0, 64'h0, 1);
      for (int m = 0; m < 2; m++)
         for (int s = 0; s < 6; s++)
         begin
            ac = u_io_bus_model.gain_word(m, s, 5'($urandom));
            u_io_bus_model.io_transfer_instruction(12'hC69, ac, -1, hd());
            u_io_bus_model.io_transfer_instruction(12'hC6A, ac, -1, hd());
            wt(2);
            note(0, 0, {52'h0, m[0], ~m[0], 6'(1 << s), 4'(s + 3 * m)}, 1);
         end
      // foreign opcode and device leave gain alone
      ac = u_io_bus_model.gain_word(0, 0, 5'h00);
      u_io_bus_model.io_transfer_instruction(12'hE6A, ac, -1, hd());
      u_io_bus_model.io_transfer_instruction(12'hC4A, ac, -1, hd());
      wt(2);
      note(0, 0, {52'h0, 1'b1, 1'b0, 6'h20, 4'h8}, 1);
      for (int i = 0; i < 8; i++)
      begin
         x = (i == 0) ? 5 : int'($urandom % 8);
         y = (i == 0) ? 1 : int'($urandom % 8);
         columnLine_n = ~(8'h01 << x);
         rowLine_n = ~(8'h01 << y);
         wt(5);
         note(1, 0, ~(64'h1 << (y * 8 + x)), 1);
      end
      // one channel in each group of eight
      for (int k = 0; k < 8; k++)
      begin
         c = chList[k];
         columnLine_n = ~(8'h01 << (c % 8));
         rowLine_n = ~(8'h01 << (c / 8));
         wt(5);
         for (int r = 0; r < 2; r++)
         begin
            v = 6'($urandom);
            ac = 12'($urandom);
            for (int j = 0; j < 6; j++)
               ac[6 + j] = v[j];
            u_io_bus_model.io_transfer_instruction(12'hC71, ac, -1, hd());
            u_io_bus_model.io_transfer_instruction(12'hC72, ac, -1, hd());
            wt(2);
            note(3, c, {58'h0, v}, 1);
         end
         for (int w = 0; w < 6; w++)
            consoleButtons[w*32 +: 32] = $urandom;
         mix = 12'h007;
         mix[6] = consoleButtons[c*3];
         mix[7] = consoleButtons[c*3 + 1];
         mix[8] = consoleButtons[c*3 + 2];
         note(2, 0, {52'h0, mix}, 0);
         u_io_bus_model.io_transfer_instruction(12'hC7A, 12'($urandom), 1, hd());
         wt(6);
         note(2, 0, 64'h0, 1);
      end
      // flag only once enabled; skip and clear
      tick();
      note(4, 0, 64'h0, 1);
      note(4, 0, 64'h0, 0);
      u_io_bus_model.io_transfer_instruction(12'hC61, 12'h000, 0, hd());
      u_io_bus_model.io_transfer_instruction(12'hC64, 12'h000, -1, hd());
      tick();
      note(4, 0, 64'h1, 1);
      note(4, 0, 64'h3, 0);
      u_io_bus_model.io_transfer_instruction(12'hC61, 12'h000, 0, hd());
      u_io_bus_model.io_transfer_instruction(12'hC62, 12'h000, -1, hd());
      wt(2);
      note(4, 0, 64'h0, 1);
      wt(2);
      finish_test();
   end
endmodule // tb_gain_channel_ctrl
`default_nettype wire
